/* logic/spi_pkg.sv */
// Summary of operation
// - Phase one: first clock edge puts the first data bit on the output.
// - Phase zero slave: first bit driven as soon as select falls.
// - After eighth shift, received byte goes to data register, done flag sets.
// - Polarity only inverts the clock; phase picks one of two formats.
// - Phase zero: first edge half period after select low, next half later.
// - Phase zero: 16 edges, sample on odd, shift on even, order by setting.
// - Phase one: 16 edges, sample on even, shift then output on odd from 3.
// - Reception double buffered; data register loads only after last bit.
// - Slave phase zero: select held low resends last received byte.
// - Master with select output, phase zero: select pulses high between bytes.
// - Phase one: first edge right after half period delay, second samples.
// - Master with byte waiting starts it at once after completion, except phase zero with select output, which waits out the gap.
// - Done flag sets half a serial clock period after the last edge.
// - Divisor is (prescale+1) times two to the (shift+1).
// - Prescale 001 doubles, 010 triples the shift divisor.
// - Baud divider runs only as master during a transfer.
// - Controller select set means master, clear means slave.
// - Data write after status read with empty loads transmit; reads receive.
package spi_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] BAUD_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] DATA_OFS = 8'h0c;
	// Control fields
	localparam int CTRL_CONTROLLER_SELECT_BIT = 0;
	localparam int CTRL_CLOCK_POLARITY_SEL_BIT = 1;
	localparam int CTRL_CLOCK_PHASE_SEL_BIT = 2;
	localparam int CTRL_SELECT_OUTPUT_EN_BIT = 3;
	localparam int CTRL_LSBF_BIT = 4;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// Baud fields: shift in [2:0], prescale in [6:4]
	localparam int BAUD_SHIFT_LSB = 0;
	localparam int BAUD_PRE_LSB = 4;
	localparam logic [7:0] BAUD_RST = 8'h00;
	// Status fields
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_TXE_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	// Pin synchroniser lanes and their reset levels
	localparam int PIN_SCK = 0;
	localparam int PIN_MOSI = 1;
	localparam int PIN_MISO = 2;
	localparam int PIN_SS = 3;
	localparam logic [3:0] PIN_RST = 4'h8;
	// Byte timing
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
	localparam int DIV_W = 11;
	localparam int CYC_W = 10;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_TRAIL,
		ST_GAP
	} xfer_state_t;

	// Bit presented on the serial output for a given shift register
	function automatic logic out_bit(input logic [7:0] sh,
		input logic lsbf);
		out_bit = lsbf ? sh[0] : sh[7];
	endfunction

	// Shift a sampled bit in at the end chosen by bit order
	function automatic logic [7:0] shift_in(input logic [7:0] sh,
		input logic b, input logic lsbf);
		shift_in = lsbf ? {b, sh[7:1]} : {sh[6:0], b};
	endfunction
endpackage

/* logic/spi_baud_div.sv */
`timescale 1ns/100ps
module spi_baud_div (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Control
	input  wire logic       run,
	input  wire logic [2:0] prescale,
	input  wire logic [2:0] shift,
	// Half serial period strobe
	output logic            tick
);
	typedef struct packed {
		logic [spi_pkg::DIV_W-1:0] cnt;
	} div_t;

	div_t                     r;
	div_t                     n;
	logic [spi_pkg::DIV_W-1:0] half;

	// Half period is (prescale+1)*2^shift, so a full period is twice that
	assign half = spi_pkg::DIV_W'({4'h0, prescale} + 7'h1) << shift;
	assign tick = run && (r.cnt == half - spi_pkg::DIV_W'(1));

	// Counter held at zero when stopped to save power
	always_comb begin
		n = r;
		if (!run || tick)
			n.cnt = '0;
		else
			n.cnt = r.cnt + spi_pkg::DIV_W'(1);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			r <= '0;
		else
			r <= n;
	end

	a_div_stopped: assert property (@(posedge hclk) disable iff (!hresetn)
		!run |=> r.cnt == '0)
		else $error("divider counted while stopped");
	a_div_period: assert property (@(posedge hclk) disable iff (!hresetn)
		(run && tick && prescale == 3'h0 && shift == 3'h1)
		##1 (run && prescale == 3'h0 && shift == 3'h1)
		|-> !tick ##1 (tick || !run))
		else $error("half period of divide by four wrong");
endmodule

/* logic/spi_core.sv */
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
module spi_core (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Serial clock pin
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe_n,
	// Master out slave in pin
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe_n,
	// Master in slave out pin
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe_n,
	// Select pin, active low
	input  wire logic        ss_n_in,
	output logic             ss_n_out,
	output logic             ss_n_oe_n
);
	typedef struct packed {
		logic [3:0]                s1;
		logic [3:0]                s2;
		logic [3:0]                s3;
		logic [3:0]                flt;
		spi_pkg::xfer_state_t      st;
		logic [4:0]                ec;
		logic                      sck_ph;
		logic                      ss_o;
		logic                      dout;
		logic                      smp;
		logic [7:0]                sh;
		logic [7:0]                tx;
		logic [7:0]                rx;
		logic [7:0]                ctrl;
		logic [7:0]                baud;
		logic                      done;
		logic                      tx_empty;
		logic                      arm_tx;
		logic                      arm_rx;
		logic [spi_pkg::CYC_W-1:0] cyc;
		logic [spi_pkg::CYC_W-1:0] hp;
		logic                      s_trail;
		logic                      a_ok;
		logic                      a_wr;
		logic [7:0]                a_ad;
		logic [31:0]               rdata;
	} core_t;

	core_t      r;
	core_t      n;
	logic       master;
	logic       clock_polarity_sel;
	logic       clock_phase_sel;
	logic       select_output_en;
	logic       lsbf;
	logic       tick;
	logic       div_run;
	logic       do_edge;
	logic       fin;
	logic       load;
	logic       din;
	logic       sck_edge;
	logic       ss_fall;
	logic       ss_rise;
	logic [4:0] ne;

	// Mode bits straight from the control register
	assign master = r.ctrl[spi_pkg::CTRL_CONTROLLER_SELECT_BIT];
	assign clock_polarity_sel   = r.ctrl[spi_pkg::CTRL_CLOCK_POLARITY_SEL_BIT];
	assign clock_phase_sel   = r.ctrl[spi_pkg::CTRL_CLOCK_PHASE_SEL_BIT];
	assign select_output_en   = r.ctrl[spi_pkg::CTRL_SELECT_OUTPUT_EN_BIT];
	assign lsbf   = r.ctrl[spi_pkg::CTRL_LSBF_BIT];

	// Divider only runs while this end clocks a byte
	assign div_run = master && (r.st != spi_pkg::ST_IDLE);

	spi_baud_div u_div (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.run      (div_run),
		.prescale (r.baud[spi_pkg::BAUD_PRE_LSB +: 3]),
		.shift    (r.baud[spi_pkg::BAUD_SHIFT_LSB +: 3]),
		.tick     (tick)
	);

	// Next state: pins, bus, then the engine so hardware sets win
	always_comb begin
		n        = r;
		do_edge  = 1'b0;
		fin      = 1'b0;
		load     = 1'b0;
		ne       = r.ec + 5'h1;

		// Three flops per pin; a change counts once stages two and three agree
		n.s1 = {ss_n_in, miso_in, mosi_in, sck_in};
		n.s2 = r.s1;
		n.s3 = r.s2;
		for (int i = 0; i < 4; i++) begin
			if (r.s2[i] == r.s3[i])
				n.flt[i] = r.s3[i];
		end
		sck_edge = n.flt[spi_pkg::PIN_SCK] != r.flt[spi_pkg::PIN_SCK];
		ss_fall  = !n.flt[spi_pkg::PIN_SS] && r.flt[spi_pkg::PIN_SS];
		ss_rise  = n.flt[spi_pkg::PIN_SS] && !r.flt[spi_pkg::PIN_SS];
		din      = master ? r.flt[spi_pkg::PIN_MISO]
			: r.flt[spi_pkg::PIN_MOSI];

		// Data phase of a write
		if (r.a_ok && r.a_wr) begin
			unique case (r.a_ad)
				spi_pkg::CTRL_OFS: n.ctrl = hwdata[7:0];
				spi_pkg::BAUD_OFS: n.baud = hwdata[7:0];
				spi_pkg::DATA_OFS: begin
					// Only a write armed by a status read lands
					if (r.arm_tx) begin
						n.tx       = hwdata[7:0];
						n.tx_empty = 1'b0;
						n.arm_tx   = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// Address phase: read data is fetched now, read side effects too
		n.a_ok = hsel && htrans[1] && hready;
		n.a_wr = hwrite;
		n.a_ad = haddr[7:0];
		if (n.a_ok && !hwrite) begin
			unique case (haddr[7:0])
				spi_pkg::CTRL_OFS: n.rdata = {24'h0, r.ctrl};
				spi_pkg::BAUD_OFS: n.rdata = {24'h0, r.baud};
				spi_pkg::STAT_OFS: begin
					n.rdata = '0;
					n.rdata[spi_pkg::STAT_DONE_BIT] = r.done;
					n.rdata[spi_pkg::STAT_TXE_BIT]  = r.tx_empty;
					n.rdata[spi_pkg::STAT_BUSY_BIT] = r.st != spi_pkg::ST_IDLE;
					n.arm_rx = r.done;
					n.arm_tx = r.tx_empty;
				end
				spi_pkg::DATA_OFS: begin
					n.rdata = {24'h0, r.rx};
					if (r.arm_rx) begin
						n.done   = 1'b0;
						n.arm_rx = 1'b0;
					end
				end
				default: n.rdata = '0;
			endcase
		end

		// Cycles since the last serial edge, to time the slave's trailer
		if (sck_edge)
			n.cyc = '0;
		else if (r.cyc != '1)
			n.cyc = r.cyc + spi_pkg::CYC_W'(1);

		if (master) begin
			// Master sequencing on half period strobes
			unique case (r.st)
				spi_pkg::ST_IDLE: begin
					n.ss_o   = 1'b1;
					n.sck_ph = 1'b0;
					if (!r.tx_empty) begin
						load   = 1'b1;
						n.ss_o = 1'b0;
						n.st   = spi_pkg::ST_SHIFT;
					end
				end
				spi_pkg::ST_SHIFT: do_edge = tick;
				spi_pkg::ST_TRAIL: begin
					if (tick) begin
						fin = 1'b1;
						if (r.tx_empty) begin
							n.ss_o = 1'b1;
							n.st   = spi_pkg::ST_IDLE;
						end else if (!clock_phase_sel && select_output_en) begin
							n.ss_o = 1'b1;
							n.st   = spi_pkg::ST_GAP;
						end else begin
							load = 1'b1;
							n.st = spi_pkg::ST_SHIFT;
						end
					end
				end
				spi_pkg::ST_GAP: begin
					// Select stays high one half period
					if (tick) begin
						load   = 1'b1;
						n.ss_o = 1'b0;
						n.st   = spi_pkg::ST_SHIFT;
					end
				end
			endcase
		end else begin
			// Slave follows the far clock while selected
			n.st     = spi_pkg::ST_IDLE;
			n.ss_o   = 1'b1;
			n.sck_ph = 1'b0;
			if (ss_rise) begin
				n.ec      = '0;
				n.s_trail = 1'b0;
			end else if (ss_fall) begin
				// Fresh select sends the transmit buffer
				load = 1'b1;
			end
			do_edge = sck_edge && !n.flt[spi_pkg::PIN_SS] && !ss_fall;
			if (r.s_trail && r.cyc >= r.hp && !ss_rise) begin
				fin       = 1'b1;
				n.s_trail = 1'b0;
			end
		end

		// One serial clock edge: sample on one parity, shift on the other
		if (do_edge) begin
			n.ec     = ne;
			n.sck_ph = !r.sck_ph;
			if (clock_phase_sel ? !ne[0] : ne[0])
				n.smp = din;
			if (clock_phase_sel && ne == spi_pkg::EDGES_PER_BYTE) begin
				// Last sample and last shift share edge sixteen
				n.sh = spi_pkg::shift_in(r.sh, din, lsbf);
			end else if (clock_phase_sel ? (ne[0] && ne != 5'h1) : !ne[0]) begin
				n.sh   = spi_pkg::shift_in(r.sh, r.smp, lsbf);
				n.dout = spi_pkg::out_bit(n.sh, lsbf);
			end
			if (clock_phase_sel && ne == 5'h1)
				n.dout = spi_pkg::out_bit(r.sh, lsbf);
			if (ne == spi_pkg::EDGES_PER_BYTE) begin
				if (master) begin
					n.st = spi_pkg::ST_TRAIL;
				end else begin
					n.s_trail = 1'b1;
					n.hp      = r.cyc;
				end
			end
		end

		// Byte complete: receive buffer and flag update together
		if (fin) begin
			n.rx   = n.sh;
			n.done = 1'b1;
			n.ec   = '0;
			// Held select resends what just came in
			n.dout = spi_pkg::out_bit(n.sh, lsbf);
		end

		// Start of a byte takes the transmit buffer
		if (load) begin
			n.sh       = r.tx;
			n.tx_empty = 1'b1;
			n.ec       = '0;
			n.dout     = spi_pkg::out_bit(r.tx, lsbf);
		end

		// Changing format or rate mid-byte as master aborts to idle
		if (r.a_ok && r.a_wr && master && r.st != spi_pkg::ST_IDLE
			&& (r.a_ad == spi_pkg::CTRL_OFS
			|| r.a_ad == spi_pkg::BAUD_OFS)) begin
			n.st     = spi_pkg::ST_IDLE;
			n.ec     = '0;
			n.sck_ph = 1'b0;
			n.ss_o   = 1'b1;
		end
	end

	// State register; pins idle deselected after reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r          <= '0;
			r.s1       <= spi_pkg::PIN_RST;
			r.s2       <= spi_pkg::PIN_RST;
			r.s3       <= spi_pkg::PIN_RST;
			r.flt      <= spi_pkg::PIN_RST;
			r.ctrl     <= spi_pkg::CTRL_RST;
			r.baud     <= spi_pkg::BAUD_RST;
			r.ss_o     <= 1'b1;
			r.tx_empty <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Bus answers at once and never errors
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = r.rdata;

	// Pins; polarity just inverts the internal phase
	assign sck_out   = clock_polarity_sel ^ r.sck_ph;
	assign sck_oe_n  = !master;
	assign mosi_out  = r.dout;
	assign mosi_oe_n = !master;
	assign miso_out  = r.dout;
	assign miso_oe_n = master || r.flt[spi_pkg::PIN_SS];
	assign ss_n_out  = r.ss_o;
	assign ss_n_oe_n = !(master && select_output_en);

	a_sck_idle_level: assert property (@(posedge hclk) disable iff (!hresetn)
		master && r.st == spi_pkg::ST_IDLE |-> sck_out == clock_polarity_sel)
		else $error("idle master clock not at polarity level");
	a_done_after_trail: assert property (@(posedge hclk) disable iff (!hresetn)
		master && r.st == spi_pkg::ST_TRAIL && tick |=> r.done)
		else $error("done flag missing after trailing half period");
	a_rx_copy: assert property (@(posedge hclk) disable iff (!hresetn)
		master && r.st == spi_pkg::ST_TRAIL && tick |=> r.rx == $past(r.sh))
		else $error("receive buffer not loaded from shift register");
	a_rx_stable: assert property (@(posedge hclk) disable iff (!hresetn)
		r.st == spi_pkg::ST_SHIFT && $past(r.st) == spi_pkg::ST_SHIFT
		|-> $stable(r.rx))
		else $error("receive buffer changed mid byte");
	a_edge_count: assert property (@(posedge hclk) disable iff (!hresetn)
		r.ec <= spi_pkg::EDGES_PER_BYTE)
		else $error("more than sixteen edges in a byte");
	a_trail_entry: assert property (@(posedge hclk) disable iff (!hresetn)
		master && r.st == spi_pkg::ST_SHIFT && tick && r.ec == 5'hf
		|=> r.st == spi_pkg::ST_TRAIL && sck_out == clock_polarity_sel)
		else $error("sixteenth edge did not end the byte");
	a_ss_gap: assert property (@(posedge hclk) disable iff (!hresetn)
		r.st == spi_pkg::ST_GAP |-> r.ss_o)
		else $error("select low during gap");
	a_back_to_back: assert property (@(posedge hclk) disable iff (!hresetn)
		master && r.st == spi_pkg::ST_TRAIL && tick && !r.tx_empty
		&& (clock_phase_sel || !select_output_en) |=> r.st == spi_pkg::ST_SHIFT && !r.ss_o)
		else $error("back to back byte delayed");
	a_slave_first: assert property (@(posedge hclk) disable iff (!hresetn)
		!master && ss_fall && !r.tx_empty |=> r.dout == spi_pkg::out_bit(
		$past(r.tx), lsbf) ##1 !miso_oe_n)
		else $error("slave first bit not driven on select");
	a_div_slave: assert property (@(posedge hclk) disable iff (!hresetn)
		!master |-> !div_run && !tick)
		else $error("divider running in slave mode");
	a_master_pins: assert property (@(posedge hclk) disable iff (!hresetn)
		master |-> !sck_oe_n && !mosi_oe_n && miso_oe_n)
		else $error("master pin directions wrong");
endmodule

/* verif/spi_far_end.sv */
`timescale 1ns/100ps
module spi_far_end (
	// Link pins
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       ss_n,
	// Format and reply byte
	input  wire logic       clock_phase_sel,
	input  wire logic       lsbf,
	input  wire logic [7:0] tx,
	// Reply line and results
	output logic            miso,
	output logic [7:0]      rx,
	output logic [7:0]      nbytes
);
	logic [7:0] acc;
	int         edges;
	int         i;

	initial begin
		miso = 1'b0;
		rx = 8'h00;
		nbytes = 8'h00;
		edges = 0;
	end

	// Bit position of serial slot k for the chosen order
	function automatic int pos(input int k);
		return lsbf ? k : 7 - k;
	endfunction

	// Select fall restarts the byte; phase zero shows bit one at once
	always @(negedge ss_n) begin
		edges = 0;
		if (!clock_phase_sel)
			miso = tx[pos(0)];
	end

	// Released line shows the inverse, so a stale bit never matches
	always @(posedge ss_n)
		miso = ~miso;

	// Every clock change while selected is one of sixteen edges
	always @(sck) begin
		if (!ss_n) begin
			edges = edges + 1;
			i = (edges - 1) / 2;
			if (edges[0] ^ clock_phase_sel)
				acc[pos(i)] = mosi;
			else if (!clock_phase_sel && i < 7)
				miso = tx[pos(i + 1)];
			if (clock_phase_sel && edges[0])
				miso = tx[pos(i)];
			// Select may stay low into the next phase-one byte
			if (edges == 16) begin
				rx = acc;
				nbytes = nbytes + 8'h01;
				edges = 0;
			end
		end
	end
endmodule

/* verif/spi_transfer_format_baud_tb.sv */
`timescale 1ns/100ps
module spi_transfer_format_baud_tb;
	// Bus side
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	// Pins of the design, of the bench and of the far end
	logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out;
	logic        miso_oe_n, ss_n_out, ss_n_oe_n, t_sck, t_mosi, t_ss;
	logic        m_miso, pha, lsb;
	logic [7:0]  m_rx, m_n, mtx;
	wire         sck_w = sck_oe_n ? t_sck : sck_out;
	wire         mosi_w = mosi_oe_n ? t_mosi : mosi_out;
	wire         miso_w = miso_oe_n ? m_miso : miso_out;
	wire         ss_w = ss_n_oe_n ? t_ss : ss_n_out;
	// Bookkeeping
	int          fails, checks, rises, eidx, exp_h;
	int          sh_tab[6] = '{0, 1, 0, 1, 2, 3};
	int          pr_tab[6] = '{0, 0, 4, 2, 1, 0};
	logic [31:0] hcnt;
	logic        sck_q, ss_q, rd_dp;
	logic [63:0] rq[$];
	logic [7:0]  mq[$];

	spi_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .sck_in(sck_w),
		.sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_w),
		.mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w),
		.miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(ss_w),
		.ss_n_out(ss_n_out), .ss_n_oe_n(ss_n_oe_n));

	spi_far_end far (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w),
		.clock_phase_sel(pha), .lsbf(lsb), .tx(mtx), .miso(m_miso), .rx(m_rx),
		.nbytes(m_n));

	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	task automatic tally_and_finish();
		if (fails == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	// One single transfer; the bus has one slave, so hready is hreadyout
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		rq.push_back({m, e});
		xfer(1'b0, a, 32'h0);
	endtask

	function automatic logic [31:0] mkc(input logic m, input logic p,
		input logic c, input logic l);
		mkc = 32'h0;
		mkc[spi_pkg::CTRL_CONTROLLER_SELECT_BIT] = m;
		mkc[spi_pkg::CTRL_CLOCK_POLARITY_SEL_BIT] = p;
		mkc[spi_pkg::CTRL_CLOCK_PHASE_SEL_BIT] = c;
		mkc[spi_pkg::CTRL_SELECT_OUTPUT_EN_BIT] = m;
		mkc[spi_pkg::CTRL_LSBF_BIT] = l;
	endfunction

	// Poll, then load a byte; without the poll the write would be lost
	task automatic send(input logic [7:0] d);
		rd(spi_pkg::STAT_OFS, 32'h2, 32'h2);
		xfer(1'b1, spi_pkg::DATA_OFS, {24'h0, d});
	endtask

	task automatic wait_n(input logic [7:0] t);
		int n;
		for (n = 0; n < 4000 && m_n !== t; n++)
			@(posedge hclk);
		chk(32'(m_n), 32'(t));
	endtask

	// Bench acts as phase-zero master, eight clocks per half period
	task automatic spi_m(input logic [7:0] tx, input logic keep,
		output logic [7:0] rx);
		t_ss <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			t_mosi <= tx[i];
			repeat (8) @(posedge hclk);
			rx[i] = miso_w;
			t_sck <= 1'b1;
			repeat (8) @(posedge hclk);
			t_sck <= 1'b0;
		end
		repeat (16) @(posedge hclk);
		t_ss <= ~keep;
	endtask

	// Read data is judged at the edge closing its data phase
	always @(posedge hclk) begin
		if (rd_dp && hreadyout && rq.size() > 0) begin
			chk(hrdata & rq[0][63:32], rq[0][31:0]);
			chk(32'(hresp), 32'h0);
			void'(rq.pop_front());
		end
		rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
	end

	// Half periods inside a byte, and select pulses
	always @(posedge hclk) begin
		sck_q <= sck_out;
		ss_q <= ss_n_out;
		hcnt <= hcnt + 32'h1;
		if (ss_n_out && !ss_q)
			rises <= rises + 1;
		if (ss_n_out === 1'b1)
			eidx <= 0;
		else if (sck_out !== sck_q && !sck_oe_n) begin
			if (eidx != 0 && eidx != 16)
				chk(hcnt, 32'(exp_h));
			hcnt <= 32'h1;
			eidx <= (eidx == 16) ? 1 : eidx + 1;
		end
	end

	// Bytes seen by the far end, oldest note first
	always @(m_n)
		if (mq.size() > 0)
			chk(32'(m_rx), 32'(mq.pop_front()));

	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		tally_and_finish();
	end

	initial begin
		logic [7:0] d, r, n0;
		int         i, h;
		{hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
		// Select idles high so the far end starts deselected
		{t_sck, t_mosi, t_ss, pha, lsb, mtx} = 13'h0400;
		{fails, checks, rises, eidx, exp_h, hcnt} = '0;
		void'($urandom(77));
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rd(spi_pkg::CTRL_OFS, 32'hffffffff, 32'h0);
		rd(spi_pkg::BAUD_OFS, 32'hffffffff, 32'h0);
		rd(spi_pkg::DATA_OFS, 32'hffffffff, 32'h0);
		rd(8'h10, 32'hffffffff, 32'h0);
		xfer(1'b1, spi_pkg::CTRL_OFS, mkc(1'b1, 1'b0, 1'b0, 1'b0));
		xfer(1'b1, spi_pkg::DATA_OFS, 32'h5a);
		repeat (40) @(posedge hclk);
		chk(32'(m_n), 32'h0);
		rd(spi_pkg::STAT_OFS, 32'h7, 32'h2);
		// Every format except LSB first in phase one, and several divisors, one byte each
		for (i = 0; i < 6; i++) begin
			pha = i[1];
			lsb = i[2];
			h = (pr_tab[i] + 1) << sh_tab[i];
			exp_h = h;
			xfer(1'b1, spi_pkg::CTRL_OFS, mkc(1'b1, i[0], pha, lsb));
			xfer(1'b1, spi_pkg::BAUD_OFS, 32'((pr_tab[i] << 4) + sh_tab[i]));
			mtx = 8'($urandom);
			d = 8'($urandom);
			n0 = m_n;
			mq.push_back(d);
			send(d);
			wait_n(n0 + 8'h01);
			repeat (h + 2) @(posedge hclk);
			rd(spi_pkg::STAT_OFS, 32'h1, 32'h1);
			if (h >= 5)
				rd(spi_pkg::DATA_OFS, 32'hff, 32'(mtx));
			chk(32'(sck_out), 32'(i[0]));
		end
		// Two bytes queued back to back in each phase
		for (i = 0; i < 2; i++) begin
			pha = i[0];
			lsb = 1'b0;
			xfer(1'b1, spi_pkg::CTRL_OFS, mkc(1'b1, 1'b0, pha, 1'b0));
			n0 = m_n;
			h = rises;
			d = 8'($urandom);
			mq.push_back(d);
			send(d);
			mq.push_back(~d);
			send(~d);
			wait_n(n0 + 8'h02);
			repeat (20) @(posedge hclk);
			chk(32'(rises - h), i ? 32'h1 : 32'h2);
		end
		// Slave: select kept low resends the byte just received
		pha = 1'b0;
		xfer(1'b1, spi_pkg::CTRL_OFS, mkc(1'b0, 1'b0, 1'b0, 1'b0));
		d = 8'($urandom);
		n0 = 8'($urandom);
		send(d);
		spi_m(n0, 1'b1, r);
		chk(32'(r), 32'(d));
		rd(spi_pkg::STAT_OFS, 32'h1, 32'h1);
		rd(spi_pkg::DATA_OFS, 32'hff, 32'(n0));
		spi_m(~n0, 1'b0, r);
		chk(32'(r), 32'(n0));
		tally_and_finish();
	end
endmodule
